// ===== hw/svdc_pkg.sv
// Constants and types shared by the supply voltage detect control block
// Behaviour
// - Writing channel_detect_enable 1 turns detection on, 0 turns it off.
// - channel_detect_enable reads 0 right after power-on or external reset release.
// - Enabling while supply already below threshold responds at once.
// - channel_response_select 0 raises voltage_detect_irq, 1 asserts detection reset.
// - Interrupt mode and enabled: fall to threshold raises voltage_detect_irq.
// - Comparator transitions are passed on unfiltered; repeats near threshold allowed.
// - Detection in low-power modes gives its interrupt only after mode release.
// - Reset mode and enabled: reset held while supply stays below threshold.
// - Both control registers reset only by power-on or external reset.
// - Enabled and below threshold sets sticky_detect_flag; it holds after recovery.
// - Disabling keeps sticky_detect_flag; only a software 0 write clears it.
// - live_compare_flag follows below-threshold state while enabled, holds nothing.
// - Detections in stop or low-power modes update flags after return to run.
// - live_compare_flag leads sticky_detect_flag by at most two clock periods.
// - Each channel has a writable channel_threshold_select passed to the comparator.
// - Drop below threshold after reset release reasserts detection reset immediately.
// - Detection in the same cycle as a software clear leaves the flag set.
// - Software writes of 1 to sticky_detect_flag do nothing.
package svdc_pkg;

    // ***************************************************************
    // Sizes and addresses
    // ***************************************************************
    localparam int          SVDC_NCH             = 2;
    localparam int          SVDC_ADR_W           = 16;
    localparam int          SVDC_DAT_W           = 32;
    localparam logic [11:0] SVDC_IDX_FLAGS_LEVEL = 12'hFC6;
    localparam logic [11:0] SVDC_IDX_MODE_ENABLE = 12'hFC7;
    localparam logic [15:0] SVDC_ADR_FLAGS_LEVEL = {2'h0, SVDC_IDX_FLAGS_LEVEL, 2'h0};
    localparam logic [15:0] SVDC_ADR_MODE_ENABLE = {2'h0, SVDC_IDX_MODE_ENABLE, 2'h0};

    // ***************************************************************
    // Field positions, per channel stride
    // ***************************************************************
    localparam int SVDC_F1_LVL    = 0;
    localparam int SVDC_F1_LIVE   = 2;
    localparam int SVDC_F1_STICKY = 3;
    localparam int SVDC_F1_STRIDE = 4;
    localparam int SVDC_F2_EN     = 0;
    localparam int SVDC_F2_MODE   = 1;
    localparam int SVDC_F2_STRIDE = 2;
    localparam int SVDC_F2_SPARE  = 4;

    // ***************************************************************
    // Reset values and encodings
    // ***************************************************************
    localparam logic [3:0] SVDC_LVL_RST   = 4'h8;
    localparam logic [1:0] SVDC_SPARE_RST = 2'h0;
    localparam logic       SVDC_MODE_IRQ  = 1'b0;
    localparam logic       SVDC_MODE_RST  = 1'b1;
    localparam int         SVDC_SYNC_STG  = 2;

    // ***************************************************************
    // Types
    // ***************************************************************
    typedef struct packed {
        logic [1:0] lvl;
        logic       mode;
        logic       en;
    } svdc_chan_cfg_s;

    typedef enum logic [2:0] {
        SVDC_LP_NORMAL,
        SVDC_LP_SLOW,
        SVDC_LP_MODE_A,
        SVDC_LP_MODE_B,
        SVDC_LP_STOP
    } svdc_lp_e;

endpackage

// ===== hw/svdc_sync.sv
// Two-stage synchroniser for asynchronous comparator levels
`timescale 1ns/1ps
`default_nettype none

module svdc_sync
    import svdc_pkg::*;
#(
    parameter int WIDTH = SVDC_NCH
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    // ***************************************************************
    // Metastability stages
    // ***************************************************************
    // First stage feeds only the second one
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= '0;
            sync_o <= '0;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule

`default_nettype wire

// ===== hw/svdc_ctrl.sv
// Supply voltage detect control: registers, flags, interrupt and reset
`timescale 1ns/1ps
`default_nettype none

module svdc_ctrl
    import svdc_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    // Wishbone classic slave
    input  wire logic [SVDC_ADR_W-1:0] adr_i,
    input  wire logic [SVDC_DAT_W-1:0] dat_i,
    output logic      [SVDC_DAT_W-1:0] dat_o,
    input  wire logic                  we_i,
    input  wire logic [3:0]            sel_i,
    input  wire logic                  cyc_i,
    input  wire logic                  stb_i,
    output logic                       ack_o,
    // Analog comparators, 1 = supply below threshold
    input  wire logic [SVDC_NCH-1:0]   cmp_below_i,
    output logic      [SVDC_NCH-1:0]   cmp_enable_o,
    output logic      [2*SVDC_NCH-1:0] cmp_level_o,
    // Low-power mode from the mode controller, same clock
    input  wire svdc_lp_e              lp_mode_i,
    // Responses
    output logic                       voltage_detect_irq_o,
    output logic                       det_reset_o
);

    // ***************************************************************
    // Functions
    // ***************************************************************
    function automatic logic reg_hit(input logic [SVDC_ADR_W-1:0] a,
                                     input logic [SVDC_ADR_W-1:0] r);
        reg_hit = (a[SVDC_ADR_W-1:2] == r[SVDC_ADR_W-1:2]);
    endfunction

    // Normal and slow modes run the core; all others are suspended
    function automatic logic core_runs(input svdc_lp_e m);
        core_runs = (m == SVDC_LP_NORMAL) || (m == SVDC_LP_SLOW);
    endfunction

    // ***************************************************************
    // Declarations
    // ***************************************************************
    svdc_chan_cfg_s [SVDC_NCH-1:0] cfg_q;
    logic           [1:0]          spare_q;
    logic           [SVDC_NCH-1:0] below_s;
    logic           [SVDC_NCH-1:0] gated_below;
    logic           [SVDC_NCH-1:0] prev_q;
    logic           [SVDC_NCH-1:0] rise;
    logic           [SVDC_NCH-1:0] pend_q;
    logic           [SVDC_NCH-1:0] detect;
    logic           [SVDC_NCH-1:0] sticky_q;
    logic           [SVDC_NCH-1:0] live_q;
    logic           [SVDC_NCH-1:0] sticky_clr;
    logic           [SVDC_NCH-1:0] irq_req;
    logic           [SVDC_NCH-1:0] rst_req;
    logic                          run;
    logic                          req;
    logic                          wr_stb;
    logic                          wr_flags;
    logic                          wr_mode;
    logic           [7:0]          flags_byte;
    logic           [7:0]          mode_byte;
    logic           [SVDC_DAT_W-1:0] rdat_d;
    logic                          ack_q;
    logic           [SVDC_DAT_W-1:0] rdat_q;
    logic                          irq_q;
    logic                          det_rst_q;

    assign run = core_runs(lp_mode_i);

    // ***************************************************************
    // Comparator synchronisation
    // ***************************************************************
    svdc_sync #(
        .WIDTH (SVDC_NCH)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i (cmp_below_i),
        .sync_o  (below_s)
    );

    // ***************************************************************
    // Bus decode
    // ***************************************************************
    // Only byte lane 0 holds register bits; other lanes ignored
    assign req      = cyc_i & stb_i & ~ack_q;
    assign wr_stb   = req & we_i & sel_i[0];
    assign wr_flags = wr_stb & reg_hit(adr_i, SVDC_ADR_FLAGS_LEVEL);
    assign wr_mode  = wr_stb & reg_hit(adr_i, SVDC_ADR_MODE_ENABLE);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_q <= '0;
        end else if (req) begin
            rdat_q <= rdat_d;
        end
    end

    // ***************************************************************
    // Read data assembly
    // ***************************************************************
    always_comb begin
        flags_byte = 8'h00;
        mode_byte  = 8'h00;
        for (int c = 0; c < SVDC_NCH; c++) begin
            flags_byte[c*SVDC_F1_STRIDE+SVDC_F1_LVL +: 2] = cfg_q[c].lvl;
            flags_byte[c*SVDC_F1_STRIDE+SVDC_F1_LIVE]     = live_q[c];
            flags_byte[c*SVDC_F1_STRIDE+SVDC_F1_STICKY]   = sticky_q[c];
            mode_byte[c*SVDC_F2_STRIDE+SVDC_F2_EN]        = cfg_q[c].en;
            mode_byte[c*SVDC_F2_STRIDE+SVDC_F2_MODE]      = cfg_q[c].mode;
        end
        // Bits 7:6 stay zero
        mode_byte[SVDC_F2_SPARE +: 2] = spare_q;
    end

    always_comb begin
        rdat_d = '0;
        if (reg_hit(adr_i, SVDC_ADR_FLAGS_LEVEL)) begin
            rdat_d[7:0] = flags_byte;
        end else if (reg_hit(adr_i, SVDC_ADR_MODE_ENABLE)) begin
            rdat_d[7:0] = mode_byte;
        end else begin
            // Unmapped: acknowledged, reads zero, writes dropped
            rdat_d = '0;
        end
    end

    // ***************************************************************
    // Spare control bits
    // ***************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            spare_q <= SVDC_SPARE_RST;
        end else if (wr_mode) begin
            spare_q <= dat_i[SVDC_F2_SPARE +: 2];
        end
    end

    // ***************************************************************
    // Per channel logic
    // ***************************************************************
    genvar g;
    generate
        for (g = 0; g < SVDC_NCH; g++) begin : g_ch

            // Configuration; rst_i is power-on or external reset only,
            // the detection reset output never loops back here.
            // One process per channel word keeps a single driver
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    cfg_q[g].en   <= 1'b0;
                    cfg_q[g].mode <= SVDC_MODE_IRQ;
                    cfg_q[g].lvl  <= SVDC_LVL_RST[2*g +: 2];
                end else begin
                    if (wr_mode) begin
                        cfg_q[g].en   <= dat_i[g*SVDC_F2_STRIDE+SVDC_F2_EN];
                        cfg_q[g].mode <= dat_i[g*SVDC_F2_STRIDE+SVDC_F2_MODE];
                    end
                    if (wr_flags) begin
                        cfg_q[g].lvl <= dat_i[g*SVDC_F1_STRIDE+SVDC_F1_LVL +: 2];
                    end
                end
            end

            // Enable gates the comparator; enabling while already below
            // yields a fresh edge at once
            assign gated_below[g] = cfg_q[g].en & below_s[g];
            // Every edge counts, no debounce, so chatter repeats requests
            assign rise[g]        = gated_below[g] & ~prev_q[g];

            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    prev_q[g] <= 1'b0;
                end else begin
                    prev_q[g] <= gated_below[g];
                end
            end

            // Edges seen while suspended wait for the return to run
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    pend_q[g] <= 1'b0;
                end else if (!run && rise[g]) begin
                    pend_q[g] <= 1'b1;
                end else if (run) begin
                    pend_q[g] <= 1'b0;
                end
            end

            assign detect[g] = run & (rise[g] | pend_q[g]);

            // Software clear: only a 0 in the flag bit acts
            assign sticky_clr[g] = wr_flags & ~dat_i[g*SVDC_F1_STRIDE+SVDC_F1_STICKY];

            // Detection wins over a clear in the same cycle
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    sticky_q[g] <= 1'b0;
                end else if (detect[g]) begin
                    sticky_q[g] <= 1'b1;
                end else if (sticky_clr[g]) begin
                    sticky_q[g] <= 1'b0;
                end
            end

            // Live flag frozen while suspended, same edge as sticky set
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    live_q[g] <= 1'b0;
                end else if (run) begin
                    live_q[g] <= gated_below[g];
                end
            end

            assign irq_req[g] = detect[g] & (cfg_q[g].mode == SVDC_MODE_IRQ);
            // Reset request is a level, not gated by low-power mode
            assign rst_req[g] = gated_below[g] & (cfg_q[g].mode == SVDC_MODE_RST);

        end
    endgenerate

    // ***************************************************************
    // Responses
    // ***************************************************************
    // Both channels share one interrupt line
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |irq_req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            det_rst_q <= 1'b0;
        end else begin
            det_rst_q <= |rst_req;
        end
    end

    // ***************************************************************
    // Outputs
    // ***************************************************************
    assign ack_o                = ack_q;
    assign dat_o                = rdat_q;
    assign voltage_detect_irq_o = irq_q;
    assign det_reset_o          = det_rst_q;

    always_comb begin
        for (int c = 0; c < SVDC_NCH; c++) begin
            cmp_enable_o[c]        = cfg_q[c].en;
            cmp_level_o[2*c +: 2]  = cfg_q[c].lvl;
        end
    end

endmodule

`default_nettype wire

// ===== dv/svdc_sva.sv
// Assertion checker for the supply voltage detect control block
`timescale 1ns/1ps
`default_nettype none
module svdc_sva
    import svdc_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic [SVDC_ADR_W-1:0] adr_i,
    input  wire logic [SVDC_DAT_W-1:0] dat_i,
    input  wire logic [SVDC_DAT_W-1:0] dat_o,
    input  wire logic                  we_i,
    input  wire logic [3:0]            sel_i,
    input  wire logic                  cyc_i,
    input  wire logic                  stb_i,
    input  wire logic                  ack_o,
    input  wire logic [SVDC_NCH-1:0]   cmp_below_i,
    input  wire logic [SVDC_NCH-1:0]   cmp_enable_o,
    input  wire logic [2*SVDC_NCH-1:0] cmp_level_o,
    input  wire svdc_lp_e              lp_mode_i,
    input  wire logic                  voltage_detect_irq_o,
    input  wire logic                  det_reset_o
);
    // ***************************************************************
    // Own copy of the comparator synchroniser
    // ***************************************************************
    logic [SVDC_NCH-1:0] meta_q;
    logic [SVDC_NCH-1:0] sync_q;
    always_ff @(posedge clk_i) begin
        meta_q <= cmp_below_i;
        sync_q <= meta_q;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_req;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_resp;
        ack_o ##1 !ack_o;
    endsequence
    a_ack_answer: assert property (s_req |=> s_resp) else $error("bus answer missing or held");
    a_read_upper: assert property (ack_o |-> dat_o[31:8] == 24'h0) else $error("read data upper bits set");
    a_unmapped_zero: assert property (ack_o && !$past(we_i) && $past(adr_i[15:2]) != SVDC_ADR_FLAGS_LEVEL[15:2]
        && $past(adr_i[15:2]) != SVDC_ADR_MODE_ENABLE[15:2] |-> dat_o == 32'h0) else $error("unmapped read not zero");
    a_reset_clear: assert property ($fell(rst_i) |-> cmp_enable_o == 2'h0 && !det_reset_o
        && !voltage_detect_irq_o) else $error("outputs not cleared by reset");
    a_level_reset: assert property ($fell(rst_i) |-> cmp_level_o == SVDC_LVL_RST) else $error("level not reset");
    a_enable_hold: assert property (!(cyc_i && stb_i && we_i && !ack_o) |=> $stable(cmp_enable_o))
        else $error("enable changed without write");
    a_level_hold: assert property (!(cyc_i && stb_i && we_i && !ack_o) |=> $stable(cmp_level_o))
        else $error("level changed without write");
    a_det_cause: assert property (det_reset_o |-> |($past(cmp_enable_o) & $past(sync_q)))
        else $error("detection reset without enabled low supply");
    a_irq_run: assert property (voltage_detect_irq_o |-> $past(lp_mode_i) inside {SVDC_LP_NORMAL, SVDC_LP_SLOW})
        else $error("interrupt given in low-power mode");
endmodule
bind svdc_ctrl svdc_sva svdc_sva_inst (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
    .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .cmp_below_i(cmp_below_i),
    .cmp_enable_o(cmp_enable_o), .cmp_level_o(cmp_level_o), .lp_mode_i(lp_mode_i),
    .voltage_detect_irq_o(voltage_detect_irq_o), .det_reset_o(det_reset_o));
`default_nettype wire

// ===== dv/svdc_cmp_model.sv
// Comparator pair model driving the supply-below levels
`timescale 1ns/1ps
`default_nettype none
module svdc_cmp_model
    import svdc_pkg::*;
(
    input  wire logic                clk_i,
    input  wire logic [SVDC_NCH-1:0] below_i,
    input  wire logic [SVDC_NCH-1:0] enable_i,
    input  wire logic [3:0]          lag_i,
    output logic      [SVDC_NCH-1:0] cmp_below_o
);
    logic [SVDC_NCH-1:0] hist_q [16];
    always_ff @(posedge clk_i) begin
        hist_q[0] <= below_i;
        for (int k = 1; k < 16; k++) hist_q[k] <= hist_q[k-1];
    end
    // Powered-down comparator rests low; no hysteresis, every crossing passes
    always_comb cmp_below_o = (lag_i == 4'h0 ? below_i : hist_q[lag_i - 4'h1]) & enable_i;
endmodule
`default_nettype wire

// ===== dv/testbench.sv
// Self-checking bench for the supply voltage detect control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin failures++; \
    $display("Error %s expected %0h seen %0h", nm, ex, gt); end end
module testbench
    import svdc_pkg::*;
;
    logic        clk_i, rst_i = 1'b1, we = 1'b0, cyc = 1'b0, stb = 1'b0, ack, irq, det;
    logic [15:0] adr = 16'h0;
    logic [31:0] dat_w = 32'h0, dat_r, rdata;
    logic [3:0]  sel = 4'h0, lag = 4'h0, cmp_lvl;
    logic [1:0]  below = 2'h0, cmp_below, cmp_en, m_lvl [2], m_st = 2'h0;
    logic [5:0]  m_mr = 6'h0;
    svdc_lp_e    lp_mode = SVDC_LP_NORMAL;
    svdc_lp_e    lpm [3] = '{SVDC_LP_MODE_A, SVDC_LP_MODE_B, SVDC_LP_STOP};
    int          failures = 0, checks = 0, cycles = 0, irq_seen = 0, exp_irq = 0;
    logic [7:0]  v;
    svdc_ctrl svdc_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(dat_w), .dat_o(dat_r), .we_i(we),
        .sel_i(sel), .cyc_i(cyc), .stb_i(stb), .ack_o(ack), .cmp_below_i(cmp_below), .cmp_enable_o(cmp_en),
        .cmp_level_o(cmp_lvl), .lp_mode_i(lp_mode), .voltage_detect_irq_o(irq), .det_reset_o(det));
    svdc_cmp_model svdc_cmp_model_inst (.clk_i(clk_i), .below_i(below), .enable_i(cmp_en), .lag_i(lag),
        .cmp_below_o(cmp_below));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // Hang guard: whole run needs under a thousand cycles
    always @(posedge clk_i) begin
        cycles++;
        if (irq === 1'b1) irq_seen++;
        if (cycles == 8000) begin
            failures++;
            end_of_test();
        end
    end
    // ***************************************************************
    // Bus and model helpers
    // ***************************************************************
    task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat_w <= d; sel <= s;
        @(posedge clk_i);
        while (ack !== 1'b1) @(posedge clk_i);
        rdata = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        wb(1'b1, a, {24'h0, d}, 4'h1);
        if (a == SVDC_ADR_MODE_ENABLE) m_mr = d[5:0];
        if (a == SVDC_ADR_FLAGS_LEVEL) for (int i = 0; i < 2; i++) begin
            m_lvl[i] = d[4*i +: 2];
            if (!d[4*i+3]) m_st[i] = 1'b0;
        end
    endtask
    function automatic logic [31:0] m_flags();
        logic run;
        logic [31:0] r;
        run = lp_mode inside {SVDC_LP_NORMAL, SVDC_LP_SLOW};
        r = 32'h0;
        for (int i = 0; i < 2; i++) r[4*i +: 4] = {m_st[i], below[i] & m_mr[2*i] & run, m_lvl[i]};
        return r;
    endfunction
    task automatic rd(input logic [15:0] a, input logic [31:0] ex);
        wb(1'b0, a, 32'h0, 4'h1);
        `CHK("read data", ex, rdata)
    endtask
    task automatic clr(input int i);
        logic [7:0] d;
        d = {1'b1, 1'b0, m_lvl[1], 1'b1, 1'b0, m_lvl[0]};
        d[4*i+3] = 1'b0;
        wr(SVDC_ADR_FLAGS_LEVEL, d);
    endtask
    task automatic ev(input int i);
        if (m_mr[2*i]) m_st[i] = 1'b1;
        if (m_mr[2*i] && !m_mr[2*i+1]) exp_irq++;
    endtask
    // Comparator change, then lag plus two synchroniser edges and margin
    task automatic set_below(input int i, input logic b);
        @(posedge clk_i);
        below[i] <= b;
        repeat (int'(lag) + 6) @(posedge clk_i);
    endtask
    task automatic end_of_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // ***************************************************************
    // Main sequence
    // ***************************************************************
    initial begin
        void'($urandom(32'hae35));
        m_lvl = '{2'h0, 2'h2};
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(SVDC_ADR_FLAGS_LEVEL, 32'h20);
        rd(SVDC_ADR_MODE_ENABLE, 32'h0);
        `CHK("level pins", 4'h8, cmp_lvl)
        $display("test reset values done");
        for (int k = 0; k < 4; k++) begin
            v = 8'($urandom);
            wr(SVDC_ADR_FLAGS_LEVEL, v | 8'h88);
            rd(SVDC_ADR_FLAGS_LEVEL, m_flags());
            wr(SVDC_ADR_MODE_ENABLE, 8'($urandom));
            rd(SVDC_ADR_MODE_ENABLE, {26'h0, m_mr});
            `CHK("level pins", {m_lvl[1], m_lvl[0]}, cmp_lvl)
            `CHK("enable pins", {m_mr[2], m_mr[0]}, cmp_en)
        end
        wb(1'b1, SVDC_ADR_FLAGS_LEVEL, 32'h0, 4'h0);
        rd(SVDC_ADR_FLAGS_LEVEL, m_flags());
        wb(1'b1, 16'h0040, 32'hFF, 4'h1);
        rd(16'h0040, 32'h0);
        rd(SVDC_ADR_MODE_ENABLE, {26'h0, m_mr});
        $display("test registers done");
        lag <= 4'($urandom_range(0, 6));
        wr(SVDC_ADR_MODE_ENABLE, 8'h00);
        wr(SVDC_ADR_FLAGS_LEVEL, (v & 8'h33) | 8'h88);
        wr(SVDC_ADR_MODE_ENABLE, 8'h01);
        repeat (500) @(posedge clk_i);
        rd(SVDC_ADR_FLAGS_LEVEL, m_flags());
        for (int k = 0; k < 3; k++) begin
            set_below(0, 1'b1);
            ev(0);
            rd(SVDC_ADR_FLAGS_LEVEL, m_flags());
            set_below(0, 1'b0);
            rd(SVDC_ADR_FLAGS_LEVEL, m_flags());
        end
        // Clear is taken on the very edge of a fresh detection
        @(posedge clk_i);
        below[0] <= 1'b1;
        repeat (int'(lag) + 1) @(posedge clk_i);
        clr(0);
        ev(0);
        rd(SVDC_ADR_FLAGS_LEVEL, m_flags());
        set_below(0, 1'b0);
        `CHK("irq count", exp_irq, irq_seen)
        wr(SVDC_ADR_MODE_ENABLE, 8'h00);
        rd(SVDC_ADR_FLAGS_LEVEL, m_flags());
        clr(0);
        rd(SVDC_ADR_FLAGS_LEVEL, m_flags());
        $display("test interrupt mode done");
        lp_mode <= SVDC_LP_SLOW;
        set_below(1, 1'b1);
        wr(SVDC_ADR_MODE_ENABLE, 8'h04);
        ev(1);
        repeat (int'(lag) + 6) @(posedge clk_i);
        rd(SVDC_ADR_FLAGS_LEVEL, m_flags());
        `CHK("irq count", exp_irq, irq_seen)
        set_below(1, 1'b0);
        wr(SVDC_ADR_MODE_ENABLE, 8'h01);
        clr(1);
        $display("test enable while low done");
        for (int k = 0; k < 3; k++) begin
            @(posedge clk_i);
            lp_mode <= lpm[k];
            set_below(0, 1'b1);
            `CHK("irq count", exp_irq, irq_seen)
            rd(SVDC_ADR_FLAGS_LEVEL, m_flags());
            @(posedge clk_i);
            lp_mode <= SVDC_LP_NORMAL;
            ev(0);
            repeat (4) @(posedge clk_i);
            `CHK("irq count", exp_irq, irq_seen)
            rd(SVDC_ADR_FLAGS_LEVEL, m_flags());
            set_below(0, 1'b0);
            clr(0);
        end
        $display("test low power done");
        wr(SVDC_ADR_MODE_ENABLE, 8'h03);
        for (int k = 0; k < 2; k++) begin
            set_below(0, 1'b1);
            ev(0);
            `CHK("detect reset", 1'b1, det)
            rd(SVDC_ADR_MODE_ENABLE, {26'h0, m_mr});
            rd(SVDC_ADR_FLAGS_LEVEL, m_flags());
            set_below(0, 1'b0);
            `CHK("detect reset", 1'b0, det)
        end
        wr(SVDC_ADR_MODE_ENABLE, 8'h01);
        wr(SVDC_ADR_MODE_ENABLE, 8'h00);
        `CHK("irq count", exp_irq, irq_seen)
        $display("test reset mode done");
        // Second external reset in mid-run: both registers back to defaults
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        m_mr = 6'h0;
        m_st = 2'h0;
        m_lvl = '{2'h0, 2'h2};
        rd(SVDC_ADR_FLAGS_LEVEL, 32'h20);
        rd(SVDC_ADR_MODE_ENABLE, 32'h0);
        `CHK("level pins", SVDC_LVL_RST, cmp_lvl)
        $display("test mid-run reset done");
        end_of_test();
    end
endmodule
`default_nettype wire
